// File: rsr_pkg.sv
package rsr_pkg;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned SYS_CLK_MHZ = 250;
  localparam int unsigned HOLD_SHORT_CYC = 66;
  localparam int unsigned HOLD_LONG_CYC = 5000;
  localparam int unsigned OSC_START_NS = 4000;
  localparam int unsigned OSC_START_CYC = (OSC_START_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned PIN_MIN_LOW_CYC = 4;
  localparam int unsigned STOP_GLITCH_CYC = 8;
  localparam int unsigned WAKE_MIN_CYC = 4;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned NUM_GPIO = 8;

  // ==========================================================================
  // Reset-cause record
  // ==========================================================================
  localparam int unsigned CAUSE_SUPPLY_BIT = 7;
  localparam int unsigned CAUSE_STOP_BIT = 6;
  localparam int unsigned CAUSE_WDT_BIT = 5;
  localparam int unsigned CAUSE_PIN_BIT = 4;
  localparam logic [7:0] CAUSE_RESET = 8'h80;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0002;

  typedef enum logic [2:0] {
    RSR_SUPPLY, RSR_PIN, RSR_WDT, RSR_DEBUG, RSR_WAKE_GPIO, RSR_WAKE_WDT
  } rsr_cause_t;
endpackage

// File: rsr_hold_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rsr_hold_if;
  import rsr_pkg::*;
  logic start;
  logic long_sel;
  logic add_osc;
  logic busy;
  logic done;
  modport ctrl (output start, output long_sel, output add_osc, input busy, input done);
  modport timer (input start, input long_sel, input add_osc, output busy, output done);
endinterface
`default_nettype wire

// File: rsr_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none
module rsr_hold_timer (
  input wire logic sys_clk,
  input wire logic nrst,
  rsr_hold_if.timer hold
);
  import rsr_pkg::*;

  // ==========================================================================
  // Hold-off counter
  // ==========================================================================
  logic [CNT_W-1:0] cnt_q;
  logic busy_q;
  logic done_q;

  function automatic logic [CNT_W-1:0] hold_len(input logic long_sel, input logic add_osc);
    logic [CNT_W-1:0] base;
    base = long_sel ? CNT_W'(HOLD_LONG_CYC) : CNT_W'(HOLD_SHORT_CYC);
    return add_osc ? CNT_W'(base + CNT_W'(OSC_START_CYC)) : base;
  endfunction

  assign hold.busy = busy_q;
  assign hold.done = done_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      // A new start restarts the count so a later cause extends the hold
      if (hold.start) begin
        cnt_q <= CNT_W'(hold_len(hold.long_sel, hold.add_osc) - 1'b1);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == '0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= CNT_W'(cnt_q - 1'b1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: rsr_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - After supply rises, hold reset until counter expires; longer with crystal.
// - Leaving supply-rise reset sets supply_rise_flag; processor fetches vector.
// - Brown-out forces reset and holds it while supply stays low.
// - Brown-out recovery runs full supply-rise sequence, setting supply_rise_flag.
// - brownout_keep_alive decides if brown-out detection works in stop state.
// - Watchdog time-out resets when select is 1, else raises interrupt.
// - Watchdog reset sets watchdog_timeout_flag.
// - Reset pin low four cycles always resets; three may. In stop the code needs 8 cycles.
// - Stay in reset while pin low; leave on first edge after release.
// - Pin reset sets pin_reset_flag.
// - Drive reset pin low open-drain during reset or when GPIO asks.
// - After internal reset keep pin low until hold-off elapses.
// - Debugger request resets all but debug unit, self-clears, sets supply flag.
// - Stop recovery holds processor 66 or 5000 cycles plus oscillator start.
// - Stop recovery touches only watchdog and oscillator control registers.
// - After stop recovery enable internal oscillator and select it.
// - At end of reset or recovery, fetch vector at 0002h/0003h.
// - Stop recovery sets sleep_wake_flag in watchdog control readout.
// - In stop, watchdog or GPIO wakes; pin or debug pin fully resets.
// - Watchdog time-out in stop sets watchdog and sleep-wake flags.
// - Enabled GPIO change either way wakes; short pulses ignored.
// - Port input register frozen in stop; captures only lasting levels.
// - Reset pin low in stop passes glitch filter before resetting.
// - Hold-off is 66 cycles, 5000 with crystal enabled.
// - Reading cause record clears its upper four flags.
module rsr_reset_ctrl (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic supply_ok,
  input wire logic brownout_detector,
  input wire logic brownout_keep_alive,
  input wire logic xtal_enable,
  input wire logic watchdog_reset_select,
  input wire logic wdt_timeout,
  input wire logic debugger_reset_request,
  input wire logic debug_pin_n,
  input wire logic reset_pin_in_n,
  input wire logic gpio_reset_drive,
  input wire logic stop_request,
  input wire logic [rsr_pkg::NUM_GPIO-1:0] gpio_in,
  input wire logic [rsr_pkg::NUM_GPIO-1:0] gpio_wake_en,
  input wire logic cause_read,
  output logic sys_reset_n,
  output logic cpu_reset_n,
  output logic debug_unit_reset_n,
  output logic debugger_request_clear,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic stop_active,
  output logic brownout_enable,
  output logic wdt_irq,
  output logic internal_rc_osc_en,
  output logic clk_sel_rc,
  output logic wdt_ctl_restore,
  output logic vector_fetch,
  output logic [15:0] vector_addr,
  output logic [7:0] reset_cause_reg,
  output logic [rsr_pkg::NUM_GPIO-1:0] port_input_reg
);
  import rsr_pkg::*;

  typedef enum {ST_SYS_HOLD, ST_PIN_WAIT, ST_RUN, ST_STOP, ST_WAKE_HOLD} rsr_state_t;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  rsr_hold_if hold ();
  rsr_state_t state_q;
  logic pin_s1_q, pin_s2_q;
  logic [3:0] pin_low_cnt_q;
  logic pin_reset_ev;
  logic bo_active;
  logic sys_ev;
  rsr_cause_t sys_cause;
  logic wake_ev;
  rsr_cause_t wake_cause_d, wake_cause_q;
  rsr_cause_t sys_cause_q;
  logic [NUM_GPIO-1:0] gpio_ref_q;
  logic [NUM_GPIO-1:0] wake_diff;
  logic [3:0] wake_cnt_q;
  logic sys_reset_n_q, cpu_reset_n_q, dbg_n_q, clr_q, pin_oe_q, stop_q, bo_en_q, irq_q;
  logic rc_en_q, rc_sel_q, wdt_rest_q, vec_q, irq_pend_q;
  logic [7:0] cause_q;
  logic [NUM_GPIO-1:0] port_q;

  rsr_hold_timer u_hold (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .hold(hold)
  );

  // ==========================================================================
  // Reset pin filter
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= reset_pin_in_n;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Our own drive must not be read back as an external reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pin_low_cnt_q <= '0;
    end else if (pin_s2_q || pin_oe_q) begin
      pin_low_cnt_q <= '0;
    end else if (pin_low_cnt_q != 4'hf) begin
      pin_low_cnt_q <= pin_low_cnt_q + 4'h1;
    end
  end

  // Three samples suffice in run so a four-cycle low always triggers
  assign pin_reset_ev = (state_q == ST_STOP) ?
    (pin_low_cnt_q >= 4'(STOP_GLITCH_CYC)) :
    (pin_low_cnt_q >= 4'(PIN_MIN_LOW_CYC - 1));

  // ==========================================================================
  // Reset source priority
  // ==========================================================================
  assign bo_active = brownout_detector && (state_q != ST_STOP || brownout_keep_alive);

  always_comb begin
    sys_ev = 1'b1;
    sys_cause = RSR_SUPPLY;
    if (!supply_ok || bo_active) begin
      sys_cause = RSR_SUPPLY;
    end else if (pin_reset_ev && state_q != ST_SYS_HOLD && state_q != ST_PIN_WAIT) begin
      sys_cause = RSR_PIN;
    end else if (wdt_timeout && watchdog_reset_select && state_q == ST_RUN) begin
      sys_cause = RSR_WDT;
    end else if (debugger_reset_request && state_q == ST_RUN) begin
      sys_cause = RSR_DEBUG;
    end else if (!debug_pin_n && state_q == ST_STOP) begin
      sys_cause = RSR_DEBUG;
    end else begin
      sys_ev = 1'b0;
    end
  end

  // ==========================================================================
  // Stop-state wake detection
  // ==========================================================================
  assign wake_diff = (gpio_in ^ gpio_ref_q) & gpio_wake_en;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      gpio_ref_q <= '0;
      wake_cnt_q <= '0;
    end else if (state_q != ST_STOP) begin
      gpio_ref_q <= gpio_in;
      wake_cnt_q <= '0;
    end else if (wake_diff == '0) begin
      wake_cnt_q <= '0;
    end else if (wake_cnt_q != 4'hf) begin
      wake_cnt_q <= wake_cnt_q + 4'h1;
    end
  end

  always_comb begin
    wake_ev = 1'b0;
    wake_cause_d = RSR_WAKE_GPIO;
    if (state_q == ST_STOP) begin
      if (wdt_timeout) begin
        wake_ev = 1'b1;
        wake_cause_d = RSR_WAKE_WDT;
      end else if (wake_cnt_q >= 4'(WAKE_MIN_CYC - 1) && wake_diff != '0) begin
        wake_ev = 1'b1;
      end
    end
  end

  assign hold.start = sys_ev || wake_ev;
  assign hold.long_sel = xtal_enable;
  assign hold.add_osc = wake_ev && !sys_ev;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= ST_SYS_HOLD;
      sys_cause_q <= RSR_SUPPLY;
      wake_cause_q <= RSR_WAKE_GPIO;
    end else if (sys_ev) begin
      state_q <= ST_SYS_HOLD;
      sys_cause_q <= sys_cause;
    end else begin
      unique case (state_q)
        ST_SYS_HOLD: begin
          // Our own drive reads back low for a few cycles, so wait for a clean high after a hold; with no hold running, go straight to run
          if (hold.done) begin
            state_q <= ST_PIN_WAIT;
          end else if (!hold.busy && !hold.start) begin
            state_q <= ST_RUN;
          end
        end
        ST_PIN_WAIT: begin
          if (pin_s2_q) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (stop_request) begin
            state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (wake_ev) begin
            state_q <= ST_WAKE_HOLD;
            wake_cause_q <= wake_cause_d;
          end
        end
        ST_WAKE_HOLD: begin
          if (hold.done) begin
            state_q <= ST_RUN;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Reset outputs and pin driver
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sys_reset_n_q <= 1'b0;
      cpu_reset_n_q <= 1'b0;
      dbg_n_q <= 1'b0;
      pin_oe_q <= 1'b1;
      stop_q <= 1'b0;
    end else begin
      sys_reset_n_q <= !sys_ev && state_q != ST_SYS_HOLD && state_q != ST_PIN_WAIT;
      cpu_reset_n_q <= !sys_ev && !wake_ev && (state_q == ST_RUN || state_q == ST_STOP);
      // Debug unit survives its own request
      dbg_n_q <= !(sys_ev && sys_cause != RSR_DEBUG);
      // Pin is released when the hold ends; pin-wait is held by the outside
      pin_oe_q <= sys_ev || (state_q == ST_SYS_HOLD && !hold.done) || gpio_reset_drive;
      stop_q <= (state_q == ST_STOP) && !wake_ev && !sys_ev;
    end
  end

  // ==========================================================================
  // Wake side effects
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rc_en_q <= 1'b1;
      rc_sel_q <= 1'b1;
      wdt_rest_q <= 1'b0;
      vec_q <= 1'b0;
      irq_q <= 1'b0;
      irq_pend_q <= 1'b0;
      clr_q <= 1'b0;
      bo_en_q <= 1'b1;
    end else begin
      // Only these two control blocks are touched on wake
      wdt_rest_q <= wake_ev && !sys_ev;
      rc_en_q <= rc_en_q || wake_ev || sys_ev;
      rc_sel_q <= rc_sel_q || wake_ev || sys_ev;
      vec_q <= !sys_ev && ((state_q == ST_PIN_WAIT && pin_s2_q) || (state_q == ST_WAKE_HOLD && hold.done));
      clr_q <= sys_ev && sys_cause == RSR_DEBUG && debugger_reset_request;
      bo_en_q <= !(state_q == ST_STOP && !brownout_keep_alive);
      if (sys_ev) begin
        irq_pend_q <= 1'b0;
      end else if (wake_ev && wake_cause_d == RSR_WAKE_WDT && !watchdog_reset_select) begin
        irq_pend_q <= 1'b1;
      end else if (state_q == ST_WAKE_HOLD && hold.done) begin
        irq_pend_q <= 1'b0;
      end
      // Interrupt pulses as the wake hold ends, in the vector-fetch cycle while cpu_reset_n is still low
      irq_q <= (state_q == ST_RUN && wdt_timeout && !watchdog_reset_select) ||
               (state_q == ST_WAKE_HOLD && hold.done && irq_pend_q);
    end
  end

  // ==========================================================================
  // Cause record
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cause_q <= CAUSE_RESET;
    end else if (state_q == ST_SYS_HOLD && hold.done || state_q == ST_WAKE_HOLD && hold.done) begin
      // New cause wins over a read in the same cycle
      cause_q <= '0;
      unique case (state_q == ST_WAKE_HOLD ? wake_cause_q : sys_cause_q)
        RSR_SUPPLY, RSR_DEBUG: cause_q[CAUSE_SUPPLY_BIT] <= 1'b1;
        RSR_PIN: cause_q[CAUSE_PIN_BIT] <= 1'b1;
        RSR_WDT: cause_q[CAUSE_WDT_BIT] <= 1'b1;
        RSR_WAKE_GPIO: cause_q[CAUSE_STOP_BIT] <= 1'b1;
        RSR_WAKE_WDT: begin
          cause_q[CAUSE_STOP_BIT] <= 1'b1;
          cause_q[CAUSE_WDT_BIT] <= 1'b1;
        end
        default: cause_q <= CAUSE_RESET;
      endcase
    end else if (cause_read) begin
      cause_q[7:4] <= 4'h0;
    end
  end

  // ==========================================================================
  // Port input capture
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      port_q <= '0;
    end else if (state_q == ST_RUN || (state_q == ST_WAKE_HOLD && hold.done)) begin
      port_q <= gpio_in;
    end
  end

  assign sys_reset_n = sys_reset_n_q;
  assign cpu_reset_n = cpu_reset_n_q;
  assign debug_unit_reset_n = dbg_n_q;
  assign debugger_request_clear = clr_q;
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = pin_oe_q;
  assign stop_active = stop_q;
  assign brownout_enable = bo_en_q;
  assign wdt_irq = irq_q;
  assign internal_rc_osc_en = rc_en_q;
  assign clk_sel_rc = rc_sel_q;
  assign wdt_ctl_restore = wdt_rest_q;
  assign vector_fetch = vec_q;
  assign vector_addr = RESET_VECTOR_ADDR;
  assign reset_cause_reg = cause_q;
  assign port_input_reg = port_q;
endmodule
`default_nettype wire

// File: rsr_reset_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsr_reset_line_model (
  input wire logic sys_clk,
  input wire logic dev_oe,
  input wire logic dev_out,
  input wire logic ext_pull,
  output logic pin_n,
  output logic board_rst_n
);
  // ==========================================================================
  // Shared reset line
  // ==========================================================================
  // Pull-up on the board: the line reads high whenever nobody sinks it
  assign pin_n = ext_pull ? 1'b0 : (dev_oe ? dev_out : 1'b1);
  // Neighbour parts see the line through their own input flop
  always_ff @(posedge sys_clk) begin
    board_rst_n <= pin_n;
  end
endmodule
`default_nettype wire

// File: rsr_reset_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rsr_reset_ctrl_monitor
  import rsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic supply_ok,
  input wire logic brownout_detector,
  input wire logic brownout_keep_alive,
  input wire logic xtal_enable,
  input wire logic watchdog_reset_select,
  input wire logic wdt_timeout,
  input wire logic reset_pin_in_n,
  input wire logic cause_read,
  input wire logic sys_reset_n,
  input wire logic cpu_reset_n,
  input wire logic debugger_request_clear,
  input wire logic reset_pin_oe,
  input wire logic stop_active,
  input wire logic brownout_enable,
  input wire logic wdt_irq,
  input wire logic internal_rc_osc_en,
  input wire logic clk_sel_rc,
  input wire logic vector_fetch,
  input wire logic [15:0] vector_addr,
  input wire logic [7:0] reset_cause_reg
);
  // ==========================================================================
  // Hold length
  // ==========================================================================
  // Armed only after a first run, so the quick exit after nrst is not judged
  logic [15:0] low_cnt_q;
  logic armed_q;
  always_ff @(posedge sys_clk) begin
    if (!nrst || sys_reset_n) begin
      low_cnt_q <= 16'h0000;
    end else if (low_cnt_q != 16'hffff) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      armed_q <= 1'b0;
    end else if (sys_reset_n) begin
      armed_q <= 1'b1;
    end
  end
  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_HOLD: assert property (armed_q && $rose(sys_reset_n) |->
    low_cnt_q >= (xtal_enable ? 16'(HOLD_LONG_CYC) : 16'(HOLD_SHORT_CYC))) else $error("hold-off too short");
  AST_OE: assert property ($fell(sys_reset_n) |-> reset_pin_oe) else $error("reset pin not pulled");
  AST_OE_HOLD: assert property (armed_q && !sys_reset_n && $fell(reset_pin_oe) |->
    low_cnt_q >= (xtal_enable ? 16'(HOLD_LONG_CYC) : 16'(HOLD_SHORT_CYC))) else $error("reset pin released early");
  AST_SUPPLY: assert property (!supply_ok |=> !sys_reset_n) else $error("no reset on low supply");
  AST_BROWNOUT: assert property (brownout_detector && (!stop_active || brownout_keep_alive) |=>
    !sys_reset_n) else $error("no reset on brown-out");
  AST_KEEP: assert property (stop_active && $past(stop_active) |->
    brownout_enable == brownout_keep_alive) else $error("brown-out enable wrong in stop");
  AST_WDT_RST: assert property (wdt_timeout && watchdog_reset_select && cpu_reset_n && sys_reset_n
    && !stop_active |=> !sys_reset_n) else $error("watchdog reset missing");
  AST_WDT_IRQ: assert property (wdt_timeout && !watchdog_reset_select && cpu_reset_n && sys_reset_n
    && !stop_active |-> ##[1:2] (wdt_irq && sys_reset_n)) else $error("watchdog irq missing");
  AST_PIN_RUN: assert property ((!reset_pin_in_n && !reset_pin_oe && !stop_active) [*4]
    |-> ##[1:4] !sys_reset_n) else $error("pin reset missed");
  AST_PIN_STOP: assert property ((!reset_pin_in_n && stop_active) [*8]
    |-> ##[1:6] !sys_reset_n) else $error("pin reset in stop missed");
  AST_DBG_CLR: assert property (debugger_request_clear |-> ##[0:1] !sys_reset_n)
    else $error("debugger bit cleared outside reset");
  AST_VEC: assert property (vector_fetch |-> vector_addr == 16'h0002) else $error("bad vector");
  AST_OSC: assert property (vector_fetch |-> internal_rc_osc_en && clk_sel_rc)
    else $error("internal oscillator not selected");
  AST_READ_CLR: assert property (cause_read && cpu_reset_n && sys_reset_n && !stop_active && !wdt_timeout
    |=> reset_cause_reg[7:4] == 4'h0) else $error("cause flags not cleared by read");
endmodule
bind rsr_reset_ctrl rsr_reset_ctrl_monitor u_mon (.sys_clk, .nrst, .supply_ok, .brownout_detector,
  .brownout_keep_alive, .xtal_enable, .watchdog_reset_select, .wdt_timeout, .reset_pin_in_n, .cause_read,
  .sys_reset_n, .cpu_reset_n, .debugger_request_clear, .reset_pin_oe, .stop_active, .brownout_enable,
  .wdt_irq, .internal_rc_osc_en, .clk_sel_rc, .vector_fetch, .vector_addr, .reset_cause_reg);
`default_nettype wire

// File: rsr_reset_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rsr_reset_ctrl_bench;
  import rsr_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, supply_ok = 1'b1, brownout_detector = 1'b0, brownout_keep_alive = 1'b0;
  logic xtal_enable = 1'b0, watchdog_reset_select = 1'b1, wdt_timeout = 1'b0, debugger_reset_request = 1'b0;
  logic debug_pin_n = 1'b1, gpio_reset_drive = 1'b0, stop_request = 1'b0, cause_read = 1'b0, ext_pull = 1'b0;
  logic [7:0] gpio_in = 8'h00, gpio_wake_en = 8'h04, reset_cause_reg, port_input_reg;
  logic reset_pin_in_n, board_rst_n, sys_reset_n, cpu_reset_n, debug_unit_reset_n, debugger_request_clear;
  logic reset_pin_out, reset_pin_oe, stop_active, brownout_enable, wdt_irq, internal_rc_osc_en, clk_sel_rc;
  logic wdt_ctl_restore, vector_fetch, irq_seen, rest_seen;
  logic [15:0] vector_addr;
  int fail_count = 0, num_checks = 0, cyc = 0;
  int unsigned n;
  always #2 sys_clk = ~sys_clk;
  rsr_reset_ctrl i_dut (.sys_clk, .nrst, .supply_ok, .brownout_detector, .brownout_keep_alive, .xtal_enable,
    .watchdog_reset_select, .wdt_timeout, .debugger_reset_request, .debug_pin_n, .reset_pin_in_n,
    .gpio_reset_drive, .stop_request, .gpio_in, .gpio_wake_en, .cause_read, .sys_reset_n, .cpu_reset_n,
    .debug_unit_reset_n, .debugger_request_clear, .reset_pin_out, .reset_pin_oe, .stop_active,
    .brownout_enable, .wdt_irq, .internal_rc_osc_en, .clk_sel_rc, .wdt_ctl_restore, .vector_fetch,
    .vector_addr, .reset_cause_reg, .port_input_reg);
  rsr_reset_line_model i_line (.sys_clk, .dev_oe(reset_pin_oe), .dev_out(reset_pin_out), .ext_pull,
    .pin_n(reset_pin_in_n), .board_rst_n);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  always @(posedge sys_clk) begin
    if (wdt_irq === 1'b1) irq_seen = 1'b1;
    if (wdt_ctl_restore === 1'b1) rest_seen = 1'b1;
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // Bounded so a missing release still reaches the report
  task automatic wait_vec(output int unsigned k);
    k = 0;
    while (vector_fetch !== 1'b1 && k < 9000) begin
      tick(1);
      k++;
    end
  endtask
  task automatic rd_cause(input logic [7:0] exp);
    tick(2);
    chk({8'h00, exp}, {8'h00, reset_cause_reg});
    cause_read = 1'b1;
    tick(1);
    cause_read = 1'b0;
    tick(1);
  endtask
  task automatic dip(input logic xt, input int unsigned min);
    xtal_enable = xt;
    supply_ok = 1'b0;
    brownout_detector = 1'b1;
    tick(5);
    chk(16'h0, {15'h0, sys_reset_n});
    chk(16'h0, {15'h0, board_rst_n});
    supply_ok = 1'b1;
    brownout_detector = 1'b0;
    wait_vec(n);
    chk(16'h1, {15'h0, n >= min});
    rd_cause(8'h80);
    xtal_enable = 1'b0;
  endtask
  task automatic pulse_wdt(input logic sel);
    watchdog_reset_select = sel;
    wdt_timeout = 1'b1;
    tick(1);
    wdt_timeout = 1'b0;
  endtask
  task automatic pin_low(input int k);
    ext_pull = 1'b1;
    tick(k);
    ext_pull = 1'b0;
  endtask
  task automatic enter_stop();
    tick(4);
    stop_request = 1'b1;
    tick(1);
    stop_request = 1'b0;
    tick(2);
    chk(16'h1, {15'h0, stop_active});
    chk({15'h0, brownout_keep_alive}, {15'h0, brownout_enable});
  endtask
  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    tick(2);
    nrst = 1'b1;
    tick(3);
    rd_cause(8'h80);
    rd_cause(8'h00);
    dip(1'b0, HOLD_SHORT_CYC);
    dip(1'b1, HOLD_LONG_CYC);
    pulse_wdt(1'b1);
    wait_vec(n);
    rd_cause(8'h20);
    irq_seen = 1'b0;
    pulse_wdt(1'b0);
    tick(4);
    chk(16'h3, {14'h0, irq_seen, sys_reset_n});
    gpio_reset_drive = 1'b1;
    tick(2);
    chk(16'h5, {13'h0, reset_pin_oe, board_rst_n, sys_reset_n});
    gpio_reset_drive = 1'b0;
    tick(4);
    pin_low(2);
    tick(10);
    chk(16'h1, {15'h0, sys_reset_n});
    pin_low(4);
    wait_vec(n);
    rd_cause(8'h10);
    pin_low(200);
    chk(16'h0, {15'h0, sys_reset_n});
    wait_vec(n);
    chk(16'h1, {15'h0, n <= 8});
    rd_cause(8'h10);
    debugger_reset_request = 1'b1;
    for (int i = 0; i < 20 && debugger_request_clear !== 1'b1; i++) tick(1);
    debugger_reset_request = 1'b0;
    chk(16'h3, {14'h0, debugger_request_clear, debug_unit_reset_n});
    wait_vec(n);
    rd_cause(8'h80);
    enter_stop();
    gpio_in = 8'h04;
    tick(2);
    gpio_in = 8'h00;
    tick(10);
    chk(16'h2, {14'h0, stop_active, port_input_reg[2]});
    gpio_in = 8'h04;
    wait_vec(n);
    chk(16'h1, {15'h0, n >= HOLD_SHORT_CYC + OSC_START_CYC});
    chk(16'h0007, {13'h0, port_input_reg[2], internal_rc_osc_en, clk_sel_rc});
    rd_cause(8'h40);
    brownout_keep_alive = 1'b1;
    enter_stop();
    irq_seen = 1'b0;
    rest_seen = 1'b0;
    pulse_wdt(1'b0);
    tick(4);
    chk(16'h2, {14'h0, sys_reset_n, cpu_reset_n});
    wait_vec(n);
    tick(4);
    chk(16'h3, {14'h0, irq_seen, rest_seen});
    rd_cause(8'h60);
    brownout_keep_alive = 1'b0;
    enter_stop();
    pin_low(4);
    tick(10);
    chk(16'h1, {15'h0, stop_active});
    pin_low(20);
    wait_vec(n);
    rd_cause(8'h10);
    enter_stop();
    debug_pin_n = 1'b0;
    tick(3);
    debug_pin_n = 1'b1;
    wait_vec(n);
    rd_cause(8'h80);
    complete_run();
  end
endmodule
`default_nettype wire
